/* File: logic/smcfs_defines.vh */
// constants for the serial memory command sequencer: depths, command layout, codes
// assumes inclusion by bare name from every design file of the block
`ifndef SMCFS_DEFINES_VH
`define SMCFS_DEFINES_VH

// ----------------------------------------------------------------
// queue geometry
// ----------------------------------------------------------------
`define SMCFS_CMD_W        20
`define SMCFS_CMD_DEPTH    4
`define SMCFS_CMD_AW       2
`define SMCFS_DAT_W        8
`define SMCFS_DAT_DEPTH    8
`define SMCFS_DAT_AW       3
`define SMCFS_CMD_FULL     4'h4
`define SMCFS_DAT_FULL     4'h8
`define SMCFS_USED_ZERO    4'h0

// ----------------------------------------------------------------
// command entry layout
// ----------------------------------------------------------------
`define SMCFS_TYPE_HI      19
`define SMCFS_TYPE_LO      18
`define SMCFS_WID_HI       17
`define SMCFS_WID_LO       16
`define SMCFS_CNT_HI       15
`define SMCFS_CNT_LO       0
`define SMCFS_LAST_BIT     12
`define SMCFS_SEL_HI       11
`define SMCFS_SEL_LO       8
`define SMCFS_BYTE_HI      7
`define SMCFS_BYTE_LO      0

// ----------------------------------------------------------------
// command types and lane widths
// ----------------------------------------------------------------
`define SMCFS_T_SEND       2'h0
`define SMCFS_T_TXCNT      2'h1
`define SMCFS_T_RXCNT      2'h2
`define SMCFS_T_DUMMY      2'h3
`define SMCFS_W_SINGLE     2'h0
`define SMCFS_W_DUAL       2'h1
`define SMCFS_W_QUAD       2'h2
`define SMCFS_W_OCTAL      2'h3
`define SMCFS_CPB_SINGLE   4'h8
`define SMCFS_CPB_DUAL     4'h4
`define SMCFS_CPB_QUAD     4'h2
`define SMCFS_CPB_OCTAL    4'h1
`define SMCFS_CYC_ONE      4'h1
`define SMCFS_CYC_ZERO     4'h0

// ----------------------------------------------------------------
// byte counts and idle pin levels
// ----------------------------------------------------------------
`define SMCFS_N_ZERO       3'h0
`define SMCFS_N_ONE        3'h1
`define SMCFS_N_TWO        3'h2
`define SMCFS_N_FOUR       3'h4
`define SMCFS_SEL_IDLE_N   4'hf
`define SMCFS_OE_OFF_N     8'hff
`define SMCFS_ZERO8        8'h00
`define SMCFS_ZERO16       16'h0000
`define SMCFS_ZERO32       32'h00000000

`endif

/* File: logic/smcfs_fifo.v */
// multi-entry queue: up to four entries pushed and popped per clock
// assumes the caller never pushes beyond free space nor pops beyond used entries
`timescale 1ns/1ps
`include "smcfs_defines.vh"

module smcfs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire               clk_i,
  input  wire               sys_rst_i,
  input  wire [2:0]         push_cnt_i,
  input  wire [4*WIDTH-1:0] push_data_i,
  input  wire [2:0]         pop_cnt_i,
  output wire [4*WIDTH-1:0] head_o,
  output reg  [3:0]         used_o
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  integer         k;

  // pointers wrap by width alone, so depth must be a power of two
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      used_o <= `SMCFS_USED_ZERO;
    end else begin
      wr_ptr <= wr_ptr + push_cnt_i[AW-1:0];
      rd_ptr <= rd_ptr + pop_cnt_i[AW-1:0];
      used_o <= used_o + {1'b0, push_cnt_i} - {1'b0, pop_cnt_i};
    end
  end

  always @(posedge clk_i) begin
    for (k = 0; k < 4; k = k + 1) begin
      if (k < push_cnt_i) begin
        mem[wr_ptr + k[AW-1:0]] <= push_data_i[k*WIDTH +: WIDTH];
      end
    end
  end

  // ----------------------------------------------------------------
  // oldest four entries, oldest in the low lane
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_head
      localparam [AW-1:0] OFF = g;
      wire [AW-1:0] ridx;
      assign ridx = rd_ptr + OFF;
      assign head_o[g*WIDTH +: WIDTH] = mem[ridx];
    end
  endgenerate

endmodule

/* File: logic/smcfs_top.v */
// command-mode sequencer of a serial memory master: queues, request ports, lane engine
// assumes an interface clock input far slower than clk_i; all software ports on clk_i
`timescale 1ns/1ps
`include "smcfs_defines.vh"

// Summary of operation
// - three bus slave ports exist; only the command side is built here
// - command requests are refused while mapped access owns the queues
// - interface engine is driven only through the three queues
// - command queue holds four twenty-bit phase entries
// - send-byte opens a transfer, sets selects for all of it
// - transmit-count sends queued bytes, ends the transfer, deselects
// - receive-count captures bytes into the receive queue, ends, deselects
// - dummy-count idles the lanes some cycles, never final, no selects
// - one command queue steers both transmit and receive halves
// - three-bit occupancy of the command queue is reported
// - full command queue: error unless blocking, else the write waits
// - transmit queue of eight bytes, four-bit occupancy reported
// - transmit pushes of one, two or four bytes per write
// - too few free transmit entries: error or wait per blocking
// - receive queue of eight bytes, four-bit occupancy reported
// - serial clock stops in a receive-count phase while the receive queue is full
// - receive pops of one, two or four bytes per read
// - too few receive bytes: error or wait per blocking
// - peek returns the oldest receive byte without popping
// - stalls hold the serial clock low with selects still asserted
module smcfs_top (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        mapped_access_select_i,
  input  wire        block_i,
  input  wire        cmd_wr_i,
  input  wire [19:0] cmd_data_i,
  output wire        cmd_ack_o,
  output wire        cmd_err_o,
  output wire        cmd_wait_o,
  input  wire        send_push_one_byte_i,
  input  wire        send_push_two_bytes_i,
  input  wire        send_push_four_bytes_i,
  input  wire [31:0] send_data_i,
  output wire        send_ack_o,
  output wire        send_err_o,
  output wire        send_wait_o,
  input  wire        recv_pop_one_byte_i,
  input  wire        recv_pop_two_bytes_i,
  input  wire        recv_pop_four_bytes_i,
  input  wire        recv_peek_byte_i,
  output reg  [31:0] recv_data_o,
  output wire        recv_ack_o,
  output wire        recv_err_o,
  output wire        recv_wait_o,
  output wire [2:0]  cmd_used_o,
  output wire [3:0]  send_used_o,
  output wire [3:0]  recv_used_o,
  output wire        busy_o,
  input  wire        if_clk_i,
  output reg         spi_clk_o,
  output wire [3:0]  spi_sel_n_o,
  input  wire [7:0]  spi_dat_i,
  output reg  [7:0]  spi_dat_o,
  output reg  [7:0]  spi_dat_oe_n_o
);

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOW  = 2'h1;
  localparam [1:0] S_HIGH = 2'h2;
  localparam [1:0] S_DONE = 2'h3;

  // ----------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------
  function [3:0] cyc_per_byte;
    input [1:0] w;
    begin
      case (w)
        `SMCFS_W_SINGLE: cyc_per_byte = `SMCFS_CPB_SINGLE;
        `SMCFS_W_DUAL:   cyc_per_byte = `SMCFS_CPB_DUAL;
        `SMCFS_W_QUAD:   cyc_per_byte = `SMCFS_CPB_QUAD;
        default:         cyc_per_byte = `SMCFS_CPB_OCTAL;
      endcase
    end
  endfunction

  // msb first; single lane sends on line 0 and listens on line 1
  function [7:0] lane_out;
    input [7:0] sh;
    input [1:0] w;
    begin
      case (w)
        `SMCFS_W_SINGLE: lane_out = {7'h00, sh[7]};
        `SMCFS_W_DUAL:   lane_out = {6'h00, sh[7:6]};
        `SMCFS_W_QUAD:   lane_out = {4'h0, sh[7:4]};
        default:         lane_out = sh;
      endcase
    end
  endfunction

  function [7:0] lane_shift;
    input [7:0] sh;
    input [1:0] w;
    begin
      case (w)
        `SMCFS_W_SINGLE: lane_shift = {sh[6:0], 1'b0};
        `SMCFS_W_DUAL:   lane_shift = {sh[5:0], 2'h0};
        `SMCFS_W_QUAD:   lane_shift = {sh[3:0], 4'h0};
        default:         lane_shift = `SMCFS_ZERO8;
      endcase
    end
  endfunction

  function [7:0] lane_in;
    input [7:0] sh;
    input [7:0] din;
    input [1:0] w;
    begin
      case (w)
        `SMCFS_W_SINGLE: lane_in = {sh[6:0], din[1]};
        `SMCFS_W_DUAL:   lane_in = {sh[5:0], din[1:0]};
        `SMCFS_W_QUAD:   lane_in = {sh[3:0], din[3:0]};
        default:         lane_in = din;
      endcase
    end
  endfunction

  // enables are active low: a zero marks a driven line
  function [7:0] lane_oe_n;
    input [1:0] w;
    begin
      case (w)
        `SMCFS_W_SINGLE: lane_oe_n = 8'hfe;
        `SMCFS_W_DUAL:   lane_oe_n = 8'hfc;
        `SMCFS_W_QUAD:   lane_oe_n = 8'hf0;
        default:         lane_oe_n = 8'h00;
      endcase
    end
  endfunction

  // widest strobe wins when several are raised together
  function [2:0] req_bytes;
    input one;
    input two;
    input four;
    begin
      if (four) begin
        req_bytes = `SMCFS_N_FOUR;
      end else if (two) begin
        req_bytes = `SMCFS_N_TWO;
      end else if (one) begin
        req_bytes = `SMCFS_N_ONE;
      end else begin
        req_bytes = `SMCFS_N_ZERO;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wire [79:0] cmd_head;
  wire [31:0] send_head;
  wire [31:0] recv_head;
  wire [3:0]  cmd_used;
  wire [2:0]  cmd_push;
  wire [2:0]  send_push;
  wire [2:0]  recv_pop;
  reg  [2:0]  cmd_pop;
  reg  [2:0]  send_pop;
  reg  [2:0]  recv_push;
  reg  [7:0]  recv_byte;
  reg  [1:0]  state;
  reg  [1:0]  ph_type;
  reg  [1:0]  ph_width;
  reg         ph_last;
  reg  [15:0] ph_left;
  reg  [3:0]  cyc_left;
  reg  [7:0]  tx_sh;
  reg  [7:0]  rx_sh;
  reg  [3:0]  sel_mask;
  reg         xfer_on;
  reg         ifc_s1;
  reg         ifc_s2;
  reg         ifc_s3;
  reg  [7:0]  din_s1;
  reg  [7:0]  din_s2;
  wire        tick;
  wire [7:0]  rx_next;

  // ----------------------------------------------------------------
  // command port
  // ----------------------------------------------------------------
  wire cmd_req  = cmd_wr_i & ~mapped_access_select_i;
  wire cmd_full = (cmd_used == `SMCFS_CMD_FULL);

  assign cmd_ack_o  = cmd_req & ~cmd_full;
  assign cmd_err_o  = (cmd_wr_i & mapped_access_select_i)
                    | (cmd_req & cmd_full & ~block_i);
  assign cmd_wait_o = cmd_req & cmd_full & block_i;
  assign cmd_push   = cmd_ack_o ? `SMCFS_N_ONE : `SMCFS_N_ZERO;
  assign cmd_used_o = cmd_used[2:0];

  // ----------------------------------------------------------------
  // transmit data port
  // ----------------------------------------------------------------
  wire [2:0] send_n   = req_bytes(send_push_one_byte_i, send_push_two_bytes_i,
                                  send_push_four_bytes_i);
  wire       send_req = (send_n != `SMCFS_N_ZERO);
  wire [3:0] send_free = `SMCFS_DAT_FULL - send_used_o;
  wire       send_fit = ({1'b0, send_n} <= send_free);
  wire       send_ok  = send_req & ~mapped_access_select_i;

  assign send_ack_o  = send_ok & send_fit;
  assign send_err_o  = (send_req & mapped_access_select_i)
                     | (send_ok & ~send_fit & ~block_i);
  assign send_wait_o = send_ok & ~send_fit & block_i;
  assign send_push   = send_ack_o ? send_n : `SMCFS_N_ZERO;

  // ----------------------------------------------------------------
  // receive data port; peek counts as a one-byte need
  // ----------------------------------------------------------------
  wire [2:0] recv_n   = req_bytes(recv_pop_one_byte_i | recv_peek_byte_i,
                                  recv_pop_two_bytes_i, recv_pop_four_bytes_i);
  wire       recv_req = (recv_n != `SMCFS_N_ZERO);
  wire       recv_fit = ({1'b0, recv_n} <= recv_used_o);
  wire       recv_ok  = recv_req & ~mapped_access_select_i;
  wire       recv_pop_req = recv_pop_one_byte_i | recv_pop_two_bytes_i
                          | recv_pop_four_bytes_i;

  assign recv_ack_o  = recv_ok & recv_fit;
  assign recv_err_o  = (recv_req & mapped_access_select_i)
                     | (recv_ok & ~recv_fit & ~block_i);
  assign recv_wait_o = recv_ok & ~recv_fit & block_i;
  assign recv_pop    = (recv_ack_o & recv_pop_req) ? recv_n : `SMCFS_N_ZERO;

  // unused upper lanes read as zero
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      recv_data_o <= `SMCFS_ZERO32;
    end else if (recv_ack_o) begin
      case (recv_n)
        `SMCFS_N_FOUR: recv_data_o <= recv_head;
        `SMCFS_N_TWO:  recv_data_o <= {`SMCFS_ZERO16, recv_head[15:0]};
        default:       recv_data_o <= {24'h000000, recv_head[7:0]};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // queues
  // ----------------------------------------------------------------
  smcfs_fifo #(
    .WIDTH (`SMCFS_CMD_W),
    .DEPTH (`SMCFS_CMD_DEPTH),
    .AW    (`SMCFS_CMD_AW)
  ) u_cmd_q (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .push_cnt_i  (cmd_push),
    .push_data_i ({60'h0, cmd_data_i}),
    .pop_cnt_i   (cmd_pop),
    .head_o      (cmd_head),
    .used_o      (cmd_used)
  );

  smcfs_fifo #(
    .WIDTH (`SMCFS_DAT_W),
    .DEPTH (`SMCFS_DAT_DEPTH),
    .AW    (`SMCFS_DAT_AW)
  ) u_send_q (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .push_cnt_i  (send_push),
    .push_data_i (send_data_i),
    .pop_cnt_i   (send_pop),
    .head_o      (send_head),
    .used_o      (send_used_o)
  );

  smcfs_fifo #(
    .WIDTH (`SMCFS_DAT_W),
    .DEPTH (`SMCFS_DAT_DEPTH),
    .AW    (`SMCFS_DAT_AW)
  ) u_recv_q (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .push_cnt_i  (recv_push),
    .push_data_i ({24'h000000, recv_byte}),
    .pop_cnt_i   (recv_pop),
    .head_o      (recv_head),
    .used_o      (recv_used_o)
  );

  // ----------------------------------------------------------------
  // interface clock and data line sampling
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ifc_s1 <= 1'b0;
      ifc_s2 <= 1'b0;
      ifc_s3 <= 1'b0;
      din_s1 <= `SMCFS_ZERO8;
      din_s2 <= `SMCFS_ZERO8;
    end else begin
      ifc_s1 <= if_clk_i;
      ifc_s2 <= ifc_s1;
      ifc_s3 <= ifc_s2;
      din_s1 <= spi_dat_i;
      din_s2 <= din_s1;
    end
  end

  // one engine step per interface clock rise; half a serial clock period per step
  assign tick    = ifc_s2 & ~ifc_s3;
  assign rx_next = lane_in(rx_sh, din_s2, ph_width);

  // ----------------------------------------------------------------
  // queue strobes from the engine; the only way it touches data
  // ----------------------------------------------------------------
  wire need_byte = (state == S_LOW) && (cyc_left == `SMCFS_CYC_ZERO);
  wire send_empty = (send_used_o == `SMCFS_USED_ZERO);
  wire recv_full  = (recv_used_o == `SMCFS_DAT_FULL);

  always @* begin
    cmd_pop   = `SMCFS_N_ZERO;
    send_pop  = `SMCFS_N_ZERO;
    recv_push = `SMCFS_N_ZERO;
    recv_byte = rx_next;
    if (tick && (state == S_IDLE) && (cmd_used != `SMCFS_USED_ZERO)) begin
      cmd_pop = `SMCFS_N_ONE;
    end
    if (tick && need_byte && (ph_type == `SMCFS_T_TXCNT) && !send_empty) begin
      send_pop = `SMCFS_N_ONE;
    end
    if (tick && (state == S_HIGH) && (ph_type == `SMCFS_T_RXCNT)
        && (cyc_left == `SMCFS_CYC_ZERO)) begin
      recv_push = `SMCFS_N_ONE;
    end
  end

  // ----------------------------------------------------------------
  // phase engine
  // ----------------------------------------------------------------
  wire [19:0] cmd_now = cmd_head[19:0];

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state          <= S_IDLE;
      ph_type        <= `SMCFS_T_SEND;
      ph_width       <= `SMCFS_W_SINGLE;
      ph_last        <= 1'b0;
      ph_left        <= `SMCFS_ZERO16;
      cyc_left       <= `SMCFS_CYC_ZERO;
      tx_sh          <= `SMCFS_ZERO8;
      rx_sh          <= `SMCFS_ZERO8;
      sel_mask       <= `SMCFS_SEL_IDLE_N;
      xfer_on        <= 1'b0;
      spi_clk_o      <= 1'b0;
      spi_dat_o      <= `SMCFS_ZERO8;
      spi_dat_oe_n_o <= `SMCFS_OE_OFF_N;
    end else if (tick) begin
      case (state)
        S_IDLE: begin
          if (cmd_used != `SMCFS_USED_ZERO) begin
            ph_type  <= cmd_now[`SMCFS_TYPE_HI:`SMCFS_TYPE_LO];
            ph_width <= cmd_now[`SMCFS_WID_HI:`SMCFS_WID_LO];
            state    <= S_LOW;
            if (cmd_now[`SMCFS_TYPE_HI:`SMCFS_TYPE_LO] == `SMCFS_T_SEND) begin
              sel_mask <= ~cmd_now[`SMCFS_SEL_HI:`SMCFS_SEL_LO];
              xfer_on  <= 1'b1;
              tx_sh    <= cmd_now[`SMCFS_BYTE_HI:`SMCFS_BYTE_LO];
              ph_last  <= cmd_now[`SMCFS_LAST_BIT];
              ph_left  <= `SMCFS_ZERO16;
              cyc_left <= cyc_per_byte(cmd_now[`SMCFS_WID_HI:`SMCFS_WID_LO]);
            end else begin
              // count phases keep the selects of the opening send-byte
              ph_last  <= (cmd_now[`SMCFS_TYPE_HI:`SMCFS_TYPE_LO]
                           != `SMCFS_T_DUMMY);
              ph_left  <= cmd_now[`SMCFS_CNT_HI:`SMCFS_CNT_LO];
              cyc_left <= `SMCFS_CYC_ZERO;
            end
          end
        end
        S_LOW: begin
          spi_clk_o <= 1'b0;
          if (cyc_left == `SMCFS_CYC_ZERO) begin
            // clock held low while a queue blocks; selects stay put
            case (ph_type)
              `SMCFS_T_TXCNT: begin
                if (!send_empty) begin
                  tx_sh    <= send_head[7:0];
                  cyc_left <= cyc_per_byte(ph_width);
                end
              end
              `SMCFS_T_RXCNT: begin
                if (!recv_full) begin
                  cyc_left <= cyc_per_byte(ph_width);
                end
              end
              default: begin
                cyc_left <= `SMCFS_CYC_ONE;
              end
            endcase
          end else begin
            spi_dat_o <= lane_out(tx_sh, ph_width);
            tx_sh     <= lane_shift(tx_sh, ph_width);
            cyc_left  <= cyc_left - `SMCFS_CYC_ONE;
            if ((ph_type == `SMCFS_T_SEND) || (ph_type == `SMCFS_T_TXCNT)) begin
              spi_dat_oe_n_o <= lane_oe_n(ph_width);
            end else begin
              spi_dat_oe_n_o <= `SMCFS_OE_OFF_N;
            end
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          spi_clk_o <= 1'b1;
          rx_sh     <= rx_next;
          if (cyc_left != `SMCFS_CYC_ZERO) begin
            state <= S_LOW;
          end else if (ph_left == `SMCFS_ZERO16) begin
            state <= S_DONE;
          end else begin
            ph_left <= ph_left - 16'h0001;
            state   <= S_LOW;
          end
        end
        S_DONE: begin
          spi_clk_o <= 1'b0;
          state     <= S_IDLE;
          if (ph_last) begin
            xfer_on        <= 1'b0;
            sel_mask       <= `SMCFS_SEL_IDLE_N;
            spi_dat_oe_n_o <= `SMCFS_OE_OFF_N;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins and status
  // ----------------------------------------------------------------
  assign spi_sel_n_o = xfer_on ? sel_mask : `SMCFS_SEL_IDLE_N;
  assign busy_o      = xfer_on | (state != S_IDLE)
                     | (cmd_used != `SMCFS_USED_ZERO);

endmodule

/* File: dv/smcfs_sva.sv */
// checker: port-level properties of the command sequencer
// assumes a bind onto smcfs_top, sees its ports only
`timescale 1ns/1ps
module smcfs_sva (
  input wire       clk_i, sys_rst_i, mapped_access_select_i, block_i,
  input wire       cmd_wr_i, cmd_ack_o, cmd_err_o, cmd_wait_o, busy_o, spi_clk_o,
  input wire       send_push_four_bytes_i, send_ack_o, recv_pop_four_bytes_i, recv_ack_o,
  input wire [2:0] cmd_used_o,
  input wire [3:0] send_used_o, recv_used_o, spi_sel_n_o,
  input wire [7:0] spi_dat_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_map; mapped_access_select_i && cmd_wr_i |-> cmd_err_o && !cmd_ack_o; endproperty
  a_map: assert property (p_map) else $error("mapped cmd taken");
  property p_cfull;
    cmd_wr_i && !mapped_access_select_i && cmd_used_o == 3'h4 |->
      (block_i ? cmd_wait_o && !cmd_err_o : cmd_err_o) && !cmd_ack_o;
  endproperty
  a_cfull: assert property (p_cfull) else $error("full cmd queue");
  property p_cmax; cmd_used_o <= 3'h4; endproperty
  a_cmax: assert property (p_cmax) else $error("cmd used");
  property p_sfull; send_push_four_bytes_i && send_used_o > 4'h4 |-> !send_ack_o; endproperty
  a_sfull: assert property (p_sfull) else $error("send overrun");
  property p_rshort; recv_pop_four_bytes_i && recv_used_o < 4'h4 |-> !recv_ack_o; endproperty
  a_rshort: assert property (p_rshort) else $error("recv underrun");
  property p_idle; !busy_o |-> spi_sel_n_o == 4'hf && !spi_clk_o; endproperty
  a_idle: assert property (p_idle) else $error("idle lines");
  // occupancy before the rising edge: the last push lands with the edge itself
  property p_rfull;
    $rose(spi_clk_o) && spi_dat_oe_n_o == 8'hff |-> $past(recv_used_o) != 4'h8;
  endproperty
  a_rfull: assert property (p_rfull) else $error("clock while full");
  property p_sclk; $rose(spi_clk_o) |-> spi_sel_n_o != 4'hf; endproperty
  a_sclk: assert property (p_sclk) else $error("clock unselected");
endmodule

/* File: dv/smcfs_mem_model.sv */
// serial memory model: answers a fixed byte on line one, msb first
// assumes mode 0 clocking and active-low selects
`timescale 1ns/1ps
module smcfs_mem_model #(
  parameter [7:0] RESP = 8'h3c
) (
  input  wire       spi_clk_i,
  input  wire [3:0] spi_sel_n_i,
  input  wire [7:0] spi_mosi_i,
  output reg  [7:0] spi_dat_o = 8'h00,
  output reg [15:0] mosi_o = 16'h0000
);
  // last sixteen bits seen on line zero, sampled on the rising clock
  always @(posedge spi_clk_i) begin
    if (sel) mosi_o <= {mosi_o[14:0], spi_mosi_i[0]};
  end
  reg  [2:0] bit_idx = 3'h0;
  wire       sel = ~&spi_sel_n_i;
  // released line shows the inverse, never a stale copy
  always @(posedge sel or negedge sel) begin
    bit_idx <= 3'h0;
    spi_dat_o <= sel ? {6'h00, RESP[7], 1'b0} : ~spi_dat_o;
  end
  // dummy cycles shift too, so turnaround keeps byte alignment
  always @(negedge spi_clk_i) begin
    if (sel) begin
      bit_idx <= bit_idx + 3'h1;
      spi_dat_o <= {6'h00, RESP[3'h6 - bit_idx], 1'b0};
    end
  end
endmodule

/* File: dv/tb_smcfs_top.sv */
// testbench: drives the sequencer ports and judges the answers
// assumes design, checker and memory model compiled first
`timescale 1ns/1ps
module tb_smcfs_top;
  localparam [7:0] RESP = 8'h3c;
  reg         clk_i = 1'b0, sys_rst_i = 1'b1, if_clk_i = 1'b0, if_run = 1'b0;
  reg         mapped_access_select_i = 1'b0, block_i = 1'b0;
  reg  [7:0]  rv = 8'h00;
  reg  [19:0] cmd_data_i = 20'h00000;
  reg  [31:0] send_data_i = 32'h00000000;
  wire        cmd_wr_i, send_push_one_byte_i, send_push_two_bytes_i, send_push_four_bytes_i;
  wire        recv_pop_one_byte_i, recv_pop_two_bytes_i, recv_pop_four_bytes_i, recv_peek_byte_i;
  wire        cmd_ack_o, cmd_err_o, cmd_wait_o, send_ack_o, send_err_o, send_wait_o;
  wire        recv_ack_o, recv_err_o, recv_wait_o, busy_o, spi_clk_o;
  wire [31:0] recv_data_o;
  wire [2:0]  cmd_used_o;
  wire [3:0]  send_used_o, recv_used_o, spi_sel_n_o;
  wire [7:0]  spi_dat_i, spi_dat_o, spi_dat_oe_n_o;
  wire [15:0] mosi;
  int         miscompares = 0, num_checks = 0;
  assign {recv_peek_byte_i, recv_pop_four_bytes_i, recv_pop_two_bytes_i, recv_pop_one_byte_i,
          send_push_four_bytes_i, send_push_two_bytes_i, send_push_one_byte_i, cmd_wr_i} = rv;
  always #2 clk_i = ~clk_i;
  always #80 if (if_run) if_clk_i = ~if_clk_i;
  smcfs_top u_smcfs_top (.*);
  smcfs_mem_model #(.RESP(RESP)) u_smcfs_mem_model (.spi_clk_i(spi_clk_o),
    .spi_sel_n_i(spi_sel_n_o), .spi_mosi_i(spi_dat_o), .spi_dat_o(spi_dat_i), .mosi_o(mosi));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request on port p held up to n cycles; r = {wait, err, ack}
  task automatic rq(input int p, input int n, output logic [2:0] r);
    @(posedge clk_i);
    #1 rv[p] = 1'b1;
    repeat (n) begin
      @(negedge clk_i);
      r = p == 0 ? {cmd_wait_o, cmd_err_o, cmd_ack_o} : p < 4 ?
          {send_wait_o, send_err_o, send_ack_o} : {recv_wait_o, recv_err_o, recv_ack_o};
      if (r[1:0] != 2'b00) break;
    end
    @(posedge clk_i);
    #1 rv[p] = 1'b0;
  endtask
  task automatic t_full();
    logic [2:0] r;
    mapped_access_select_i = 1'b1;
    cmd_data_i = 20'h00100;
    rq(0, 4, r);
    chk("mapped", r, 3'b010);
    chk("busy", busy_o, 32'h0);
    mapped_access_select_i = 1'b0;
    repeat (4) rq(0, 4, r);
    chk("cmd used", cmd_used_o, 32'h4);
    rq(0, 4, r);
    chk("cmd full", r, 3'b010);
    send_data_i = 32'h44332211;
    rq(3, 4, r);
    rq(3, 4, r);
    chk("send used", send_used_o, 32'h8);
    rq(3, 4, r);
    chk("send full", r, 3'b010);
    rq(4, 4, r);
    chk("recv empty", r, 3'b010);
    block_i = 1'b1;
    rq(0, 6, r);
    chk("cmd stall", r, 3'b100);
    rq(1, 6, r);
    chk("send stall", r, 3'b100);
    rq(6, 6, r);
    chk("recv stall", r, 3'b100);
    block_i = 1'b0;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    chk("cleared", {cmd_used_o, send_used_o}, 32'h0);
  endtask
  // nine bytes requested, only eight fit: clock must park mid-transfer
  task automatic t_read();
    logic [2:0] r;
    if_run = 1'b1;
    cmd_data_i = 20'h00103;
    rq(0, 4, r);
    cmd_data_i = 20'h80008;
    rq(0, 4, r);
    for (int i = 0; i < 8000 && recv_used_o !== 4'h8; i++) @(posedge clk_i);
    repeat (400) @(posedge clk_i);
    #1;
    chk("parked", {recv_used_o, spi_sel_n_o, spi_clk_o, spi_dat_oe_n_o},
        {4'h8, 4'he, 1'b0, 8'hff});
    rq(7, 4, r);
    chk("peek", {recv_data_o[7:0], recv_used_o}, {RESP, 4'h8});
    rq(6, 4, r);
    chk("pop four", recv_data_o, {4{RESP}});
    rq(5, 4, r);
    chk("pop two", recv_data_o, {16'h0000, RESP, RESP});
    for (int i = 0; i < 6000 && spi_sel_n_o !== 4'hf; i++) @(posedge clk_i);
    #1;
    chk("rx end", recv_used_o, 32'h3);
    rq(5, 4, r);
    rq(4, 4, r);
    chk("drained", recv_used_o, 32'h0);
  endtask
  task automatic t_write();
    logic [2:0] r;
    cmd_data_i = 20'h00202;
    rq(0, 4, r);
    cmd_data_i = 20'hc0001;
    rq(0, 4, r);
    cmd_data_i = 20'h40001;
    rq(0, 4, r);
    repeat (2000) @(posedge clk_i);
    #1;
    chk("tx paused", {spi_sel_n_o, spi_clk_o, busy_o, spi_dat_oe_n_o},
        {4'hd, 1'b0, 1'b1, 8'hff});
    send_data_i = 32'h0000c35a;
    rq(2, 4, r);
    for (int i = 0; i < 6000 && spi_sel_n_o !== 4'hf; i++) @(posedge clk_i);
    #1;
    chk("tx done", {send_used_o, cmd_used_o, busy_o}, 32'h0);
    chk("tx bits", mosi, 32'h5ac3);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    t_full();
    t_read();
    t_write();
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule
bind smcfs_top smcfs_sva u_smcfs_sva (.*);
